// ### logic/pbsr_pkg.sv
// Purpose: Constants for the PHY basic status register block
// Assumes: 5-bit management register addresses, 16-bit register data
// Notes: Field positions follow the basic status register layout
package pbsr_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] BASIC_STATUS_ADDR = 5'h01;
	localparam logic [4:0] EXT_STATUS_ADDR = 5'h0f;
	localparam logic [15:0] BASIC_STATUS_RESET = 16'h7949;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int T4_ABLE_BIT = 15;
	localparam int FD100X_ABLE_BIT = 14;
	localparam int HD100X_ABLE_BIT = 13;
	localparam int FD10_ABLE_BIT = 12;
	localparam int HD10_ABLE_BIT = 11;
	localparam int FD_T2_ABLE_BIT = 10;
	localparam int HD_T2_ABLE_BIT = 9;
	localparam int EXT_STATUS_BIT = 8;
	localparam int RESERVED_BIT = 7;
	localparam int PREAMBLE_SUPP_BIT = 6;
	localparam int AN_DONE_BIT = 5;
	localparam int REMOTE_FAULT_BIT = 4;
	localparam int AN_ABLE_BIT = 3;
	localparam int LINK_BIT = 2;
	localparam int JABBER_BIT = 1;
	localparam int EXT_CAP_BIT = 0;

	// ************************************************************
	// Preamble tracking
	// ************************************************************
	localparam int PREAMBLE_BITS = 32;
	localparam int PRE_CNT_W = 6;
	localparam int SYNC_STAGES = 2;
endpackage : pbsr_pkg

// ### logic/pbsr_sync.sv
// Purpose: Two-flop synchroniser for asynchronous status levels
// Assumes: Inputs are slow levels, not pulses
// Notes: Stage one feeds stage two only
module pbsr_sync #(
	parameter int WIDTH = 5
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	initial
	begin
		if (WIDTH < 1)
			$error("pbsr_sync: WIDTH must be at least 1");
	end

	// ************************************************************
	// Capture chain
	// ************************************************************
	// First stage is read by the second stage alone
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : pbsr_sync

// ### logic/pbsr_status.sv
// Purpose: Basic status register of a tri-speed PHY management set
// Assumes: Frame engine on core_clk_in gives decoded read/write strobes
// Notes: Line-side status levels are asynchronous and synchronised here
module pbsr_status #(
	parameter bit FD100X_ABLE = 1'b1
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [pbsr_pkg::ADDR_W-1:0] mgmt_addr_in,
	input wire logic mgmt_rd_in,
	input wire logic mgmt_wr_in,
	input wire logic [pbsr_pkg::DATA_W-1:0] mgmt_wdata_in,
	input wire logic mgmt_one_bit_in,
	input wire logic mgmt_zero_bit_in,
	input wire logic mgmt_bad_opcode_in,
	input wire logic mgmt_bad_turn_in,
	input wire logic link_good_in,
	input wire logic far_end_fault_in,
	input wire logic partner_fault_in,
	input wire logic jabber_in,
	input wire logic an_complete_in,
	output logic [pbsr_pkg::DATA_W-1:0] mgmt_rdata_out,
	output logic mgmt_rvalid_out,
	output logic preamble_ok_out
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic [4:0] line_sync;
	logic link_s;
	logic far_fault_s;
	logic partner_fault_s;
	logic jabber_s;
	logic an_done_s;
	logic rd_hit;
	logic fault_event;
	logic remote_fault_ff;
	logic jabber_ff;
	logic link_ff;
	logic [pbsr_pkg::DATA_W-1:0] rdata_ff;
	logic rvalid_ff;
	logic preamble_ok_ff;
	logic [pbsr_pkg::PRE_CNT_W-1:0] pre_cnt_ff;
	logic [pbsr_pkg::PRE_CNT_W-1:0] nxt_pre_cnt;
	logic [pbsr_pkg::DATA_W-1:0] status_word;
	logic unused_wr;

	initial
	begin
		if (pbsr_pkg::PREAMBLE_BITS >= (1 << pbsr_pkg::PRE_CNT_W))
			$error("pbsr_status: preamble counter too narrow");
	end

	// Register is read-only in every bit, so writes have no effect
	assign unused_wr = mgmt_wr_in ^ (^mgmt_wdata_in);

	// ************************************************************
	// Line-side synchronisation
	// ************************************************************
	pbsr_sync #(
		.WIDTH(5)
	) u_line_sync (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.async_in({an_complete_in, jabber_in, partner_fault_in, far_end_fault_in,
			link_good_in}),
		.sync_out(line_sync)
	);

	assign link_s = line_sync[0];
	assign far_fault_s = line_sync[1];
	assign partner_fault_s = line_sync[2];
	assign jabber_s = line_sync[3];
	assign an_done_s = line_sync[4];

	// Either fault source raises the remote fault latch
	assign fault_event = far_fault_s | partner_fault_s;
	assign rd_hit = mgmt_rd_in && (mgmt_addr_in == pbsr_pkg::BASIC_STATUS_ADDR);

	// ************************************************************
	// Read word assembly
	// ************************************************************
	// Fixed abilities are constants; only bits 5, 4, 2 and 1 move
	always_comb
	begin
		status_word = '0;
		status_word[pbsr_pkg::T4_ABLE_BIT] = 1'b0;
		status_word[pbsr_pkg::FD100X_ABLE_BIT] = FD100X_ABLE;
		status_word[pbsr_pkg::HD100X_ABLE_BIT] = 1'b1;
		status_word[pbsr_pkg::FD10_ABLE_BIT] = 1'b1;
		status_word[pbsr_pkg::HD10_ABLE_BIT] = 1'b1;
		status_word[pbsr_pkg::FD_T2_ABLE_BIT] = 1'b0;
		status_word[pbsr_pkg::HD_T2_ABLE_BIT] = 1'b0;
		status_word[pbsr_pkg::EXT_STATUS_BIT] = 1'b1;
		status_word[pbsr_pkg::RESERVED_BIT] = 1'b0;
		status_word[pbsr_pkg::PREAMBLE_SUPP_BIT] = 1'b1;
		status_word[pbsr_pkg::AN_DONE_BIT] = an_done_s;
		status_word[pbsr_pkg::REMOTE_FAULT_BIT] = remote_fault_ff;
		status_word[pbsr_pkg::AN_ABLE_BIT] = 1'b1;
		status_word[pbsr_pkg::LINK_BIT] = link_ff;
		status_word[pbsr_pkg::JABBER_BIT] = jabber_ff;
		status_word[pbsr_pkg::EXT_CAP_BIT] = 1'b1;
	end

	// Read data registered; latched bits show their pre-read value
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			rdata_ff <= '0;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= rd_hit;
			if (rd_hit)
				rdata_ff <= status_word;
		end
	end

	// ************************************************************
	// Latched status bits
	// ************************************************************
	// Remote fault: a fault in the read cycle wins over the clear
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			remote_fault_ff <= 1'b0;
		else if (fault_event)
			remote_fault_ff <= 1'b1;
		else if (rd_hit)
			remote_fault_ff <= 1'b0;
	end

	// Jabber: cleared by a read only when the condition has gone
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			jabber_ff <= 1'b0;
		else if (jabber_s)
			jabber_ff <= 1'b1;
		else if (rd_hit)
			jabber_ff <= 1'b0;
	end

	// Link: failure wins over the read that would set it again
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			link_ff <= 1'b0;
		else if (!link_s)
			link_ff <= 1'b0;
		else if (rd_hit)
			link_ff <= 1'b1;
	end

	// ************************************************************
	// Preamble suppression tracking
	// ************************************************************
	// Counts consecutive one bits; a zero bit restarts the run
	always_comb
	begin
		nxt_pre_cnt = pre_cnt_ff;
		if (mgmt_zero_bit_in)
			nxt_pre_cnt = '0;
		else if (mgmt_one_bit_in && !preamble_ok_ff)
			nxt_pre_cnt = pre_cnt_ff + 1'b1;
	end

	// Bad opcode or turnaround forces a full preamble again
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			pre_cnt_ff <= '0;
			preamble_ok_ff <= 1'b0;
		end
		else if (mgmt_bad_opcode_in || mgmt_bad_turn_in)
		begin
			pre_cnt_ff <= '0;
			preamble_ok_ff <= 1'b0;
		end
		else
		begin
			pre_cnt_ff <= preamble_ok_ff ? '0 : nxt_pre_cnt;
			if (nxt_pre_cnt == (pbsr_pkg::PRE_CNT_W)'(pbsr_pkg::PREAMBLE_BITS))
				preamble_ok_ff <= 1'b1;
		end
	end

	assign mgmt_rdata_out = rdata_ff;
	assign mgmt_rvalid_out = rvalid_ff;
	assign preamble_ok_out = preamble_ok_ff;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_t4_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> !mgmt_rdata_out[15])
		else $error("100BASE-T4 ability bit read as 1");

	a_fd100x_bit: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[14] == FD100X_ABLE)
		else $error("100BASE-X full duplex bit wrong");

	a_hd100x_bit: assert property (@(posedge core_clk_in) disable iff (reset_in)
		rd_hit |=> mgmt_rvalid_out && mgmt_rdata_out[13])
		else $error("100BASE-X half duplex bit not 1");

	a_ten_caps: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[12:11] == 2'h3)
		else $error("10BASE-T ability bits not 1");

	a_t2_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[10:9] == 2'h0)
		else $error("100BASE-T2 ability bits not 0");

	a_ext_status: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[8])
		else $error("Extended status bit not 1");

	a_resv_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> !mgmt_rdata_out[7])
		else $error("Reserved bit read as 1");

	a_preamble_relearn: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(mgmt_bad_opcode_in || mgmt_bad_turn_in) |=> !preamble_ok_out ##1 !preamble_ok_out)
		else $error("Preamble not required after bad frame");

	a_preamble_cap: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[6])
		else $error("Preamble suppression bit not 1");

	a_an_live: assert property (@(posedge core_clk_in) disable iff (reset_in)
		rd_hit |=> mgmt_rdata_out[5] == $past(an_done_s))
		else $error("Auto-negotiation done bit not live");

	a_fault_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(remote_fault_ff && !rd_hit) |=> remote_fault_ff)
		else $error("Remote fault dropped without a read");

	a_fault_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(far_fault_s || partner_fault_s) |=> remote_fault_ff)
		else $error("Remote fault not latched");

	// Read with no fault present must drop the latch
	a_fault_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(rd_hit && !fault_event) |=> !remote_fault_ff)
		else $error("Remote fault not cleared by read");

	a_an_able: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[3])
		else $error("Auto-negotiation ability bit not 1");

	a_link_fail: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!link_s |=> !link_ff)
		else $error("Link bit not cleared on failure");

	a_link_recover: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(!link_ff && link_s && rd_hit) |=> link_ff && !mgmt_rdata_out[2])
		else $error("Link bit recovery wrong");

	// A cleared link bit never comes back without a read
	a_link_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(!link_ff && !rd_hit) |=> !link_ff)
		else $error("Link bit set without a read");

	a_jabber_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
		jabber_s |=> jabber_ff)
		else $error("Jabber not latched");

	a_jabber_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(jabber_ff && !rd_hit) |=> jabber_ff)
		else $error("Jabber dropped without a read");

	// Suppression may only start on a counted one bit
	a_pre_count: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(!preamble_ok_out && !mgmt_one_bit_in) |=> !preamble_ok_out)
		else $error("Preamble ok rose without a one bit");

	a_ext_cap: assert property (@(posedge core_clk_in) disable iff (reset_in)
		mgmt_rvalid_out |-> mgmt_rdata_out[0])
		else $error("Extended capability bit not 1");

	a_jabber_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(rd_hit && !jabber_s) |=> !jabber_ff)
		else $error("Jabber flag not cleared by read");
endmodule : pbsr_status

// ### testbench/pbsr_mgmt_model.sv
// Purpose: Station manager model driving the status register's strobes
// Assumes: Strobes change just after a rising edge and are held across it
// Notes: Released address and data show the inverse of their last value
module pbsr_mgmt_model (
	input wire logic core_clk_in,
	input wire logic [15:0] mgmt_rdata_in,
	input wire logic mgmt_rvalid_in,
	output logic [4:0] mgmt_addr_out,
	output logic mgmt_rd_out,
	output logic mgmt_wr_out,
	output logic [15:0] mgmt_wdata_out,
	output logic mgmt_one_bit_out,
	output logic mgmt_zero_bit_out,
	output logic mgmt_bad_opcode_out,
	output logic mgmt_bad_turn_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// Management requests
	// ************************************************************
	// Idle bus at time zero
	initial
	begin
		{mgmt_addr_out, mgmt_rd_out, mgmt_wr_out, mgmt_wdata_out} = '0;
		{mgmt_one_bit_out, mgmt_zero_bit_out, mgmt_bad_opcode_out, mgmt_bad_turn_out} = '0;
	end

	// Single read, or two back-to-back reads for the present link state
	task automatic rd(input logic [4:0] a, input bit two, output logic [15:0] w1,
		output logic [15:0] w2, output logic v);
		@(posedge core_clk_in);
		mgmt_addr_out <= a;
		mgmt_rd_out <= 1'b1;
		@(posedge core_clk_in);
		if (two)
		begin
			#1;
			w1 = mgmt_rdata_in;
			@(posedge core_clk_in);
		end
		mgmt_rd_out <= 1'b0;
		mgmt_addr_out <= ~a;
		#1;
		w2 = mgmt_rdata_in;
		v = mgmt_rvalid_in;
		if (!two)
			w1 = w2;
	endtask : rd

	// Write strobe; the register should shrug it off
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		mgmt_addr_out <= a;
		mgmt_wdata_out <= d;
		mgmt_wr_out <= 1'b1;
		@(posedge core_clk_in);
		mgmt_wr_out <= 1'b0;
		mgmt_wdata_out <= ~d;
		mgmt_addr_out <= ~a;
	endtask : wr

	// Sampled bits every other cycle, as a slow management clock gives
	task automatic bits(input logic b, input int n);
		repeat (n)
		begin
			@(posedge core_clk_in);
			mgmt_one_bit_out <= b;
			mgmt_zero_bit_out <= ~b;
			@(posedge core_clk_in);
			mgmt_one_bit_out <= 1'b0;
			mgmt_zero_bit_out <= 1'b0;
		end
		#1;
	endtask : bits

	// Bad opcode or bad turnaround pulse from the frame engine
	task automatic bad(input bit turn);
		@(posedge core_clk_in);
		mgmt_bad_opcode_out <= !turn;
		mgmt_bad_turn_out <= turn;
		@(posedge core_clk_in);
		mgmt_bad_opcode_out <= 1'b0;
		mgmt_bad_turn_out <= 1'b0;
		#1;
	endtask : bad
endmodule : pbsr_mgmt_model

// ### testbench/tb_phy_basic_status_register.sv
// Purpose: Self-checking bench for the basic status register
// Assumes: Line-side levels are held five cycles before a read
// Notes: Latch model is updated at each settle and each read
`define PBSR_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_phy_basic_status_register;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] addr;
	logic rd, wr, one, zero, bad_op, bad_turn, rvalid, pre_ok;
	logic [15:0] wdata, rdata, last, w1, w2;
	logic link = 0, far = 0, part = 0, jab = 0, an = 0, v;
	bit rf_m, jab_m, lnk_m;
	int n_mismatch = 0, checked = 0, cycles = 0;
	// ************************************************************
	// Model, stimulus and checks
	// ************************************************************
	pbsr_status #(.FD100X_ABLE(1'b1)) i_dut (.core_clk_in(core_clk), .reset_in(reset),
		.mgmt_addr_in(addr), .mgmt_rd_in(rd), .mgmt_wr_in(wr), .mgmt_wdata_in(wdata),
		.mgmt_one_bit_in(one), .mgmt_zero_bit_in(zero), .mgmt_bad_opcode_in(bad_op),
		.mgmt_bad_turn_in(bad_turn), .link_good_in(link), .far_end_fault_in(far),
		.partner_fault_in(part), .jabber_in(jab), .an_complete_in(an),
		.mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid), .preamble_ok_out(pre_ok));
	pbsr_mgmt_model i_sme (.core_clk_in(core_clk), .mgmt_rdata_in(rdata),
		.mgmt_rvalid_in(rvalid), .mgmt_addr_out(addr), .mgmt_rd_out(rd), .mgmt_wr_out(wr),
		.mgmt_wdata_out(wdata), .mgmt_one_bit_out(one), .mgmt_zero_bit_out(zero),
		.mgmt_bad_opcode_out(bad_op), .mgmt_bad_turn_out(bad_turn));

	// 40 MHz clock
	initial
		forever #12.5 core_clk = ~core_clk;

	// Fixed bits plus live and latched status
	function automatic logic [15:0] exp_word();
		return 16'h7949 | {10'h0, an, rf_m, 1'b0, lnk_m, jab_m, 1'b0};
	endfunction : exp_word

	// Read side effects: set wins over clear, failure wins over set
	function automatic void after_read();
		rf_m = far | part;
		jab_m = jab;
		lnk_m = link;
	endfunction : after_read

	// Hold levels long enough to cross the synchronisers
	task automatic settle();
		repeat (5) @(posedge core_clk);
		if (far | part)
			rf_m = 1;
		if (jab)
			jab_m = 1;
		if (!link)
			lnk_m = 0;
	endtask : settle

	task automatic check_read(input bit two);
		logic [15:0] e1;
		e1 = exp_word();
		i_sme.rd(5'h01, two, w1, w2, v);
		`PBSR_CHK("word", {1'b1, e1}, {v, w1})
		after_read();
		if (two)
		begin
			`PBSR_CHK("second word", exp_word(), w2)
			after_read();
		end
		last = w2;
	endtask : check_read

	task automatic do_reset(input int n);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (n) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		{rf_m, jab_m, lnk_m} = '0;
		last = '0;
		`PBSR_CHK("reset outs", 18'h0, {rdata, rvalid, pre_ok})
	endtask : do_reset

	task automatic end_of_test();
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// Hang guard, well above the expected run of about 1300 cycles
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'hc9e6d26b));
		do_reset(20);
		for (int k = 0; k < 2; k++)
		begin
			i_sme.bits(1'b1, 31);
			`PBSR_CHK("early ok", 1'b0, pre_ok)
			if (k == 0)
				i_sme.bits(1'b0, 1);
		end
		i_sme.bits(1'b1, 1);
		`PBSR_CHK("ok", 1'b1, pre_ok)
		for (int k = 0; k < 2; k++)
		begin
			i_sme.bad(k[0]);
			`PBSR_CHK("ok after bad", 1'b0, pre_ok)
			i_sme.bits(1'b1, 32);
			`PBSR_CHK("ok again", 1'b1, pre_ok)
		end
		repeat (80)
		begin
			@(posedge core_clk);
			{far, part, jab, an} <= 4'($urandom);
			link <= ($urandom % 4) != 0;
			settle();
			i_sme.wr(5'h01, 16'($urandom));
			i_sme.rd(5'(2 + $urandom % 30), 1'b0, w1, w2, v);
			`PBSR_CHK("stray read", {1'b0, last}, {v, w1})
			check_read(1'($urandom));
		end
		@(posedge core_clk);
		{link, far, part, jab, an} <= 5'b10001;
		settle();
		do_reset(3);
		// Let the synchronisers refill before the double read
		settle();
		check_read(1'b1);
		end_of_test();
	end
endmodule : tb_phy_basic_status_register
